/* File: design/tpsq_pkg.sv */
package tpsq_pkg;
    // register byte offsets on the avalon slave
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_STEP = 6'h04;
    localparam logic [5:0] OFS_CHAR0 = 6'h08;
    localparam logic [5:0] OFS_STATUS = 6'h20;
    // control field positions
    localparam int CTRL_RUN = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_PAT_LSB = 3;
    localparam int CTRL_CODE8 = 5;
    localparam int CTRL_RATE_LSB = 6;
    localparam int CTRL_RANGE_B = 10;
    localparam int CTRL_LEN_LSB = 11;
    localparam logic [31:0] CTRL_RESET = 32'h0000_3000;
    localparam logic [7:0] CHAR_RESET = 8'hff;
    // status field positions
    localparam int STAT_MSG_EN = 0;
    localparam int STAT_CHAR_END = 1;
    localparam int STAT_RUN = 2;
    localparam int STAT_BITS_LSB = 4;
    localparam int STAT_SEL_LSB = 8;
    localparam int STAT_MSG_LSB = 12;
    // serialiser and sequencing
    localparam int REG_STAGES = 10;
    localparam int FRAME_BITS = REG_STAGES + 1;
    localparam logic [3:0] FRAME_LEN_8 = 4'hb;
    localparam logic [3:0] FRAME_LEN_5 = 4'h7;
    localparam logic [10:0] MARK_FILL = 11'h7ff;
    localparam logic [6:0] TICKS_LAST = 7'h63;
    localparam int SEL_CHARS = 6;
    localparam logic [3:0] SEL_LAST = 4'h5;
    localparam int MSG_LEN = 16;
    localparam logic [3:0] MSG_LAST = 4'hf;
    localparam logic [8:0] LFSR_SEED = 9'h1ff;
    // time base
    localparam logic [3:0] RATE_POS_192 = 4'h9;
    localparam logic [3:0] RATE_POS_EXT = 4'ha;
    localparam logic [7:0] DIV_192_LAST = 8'hbf;

    typedef enum logic [1:0] {
        MODE_FREE_RUN = 2'b00,
        MODE_PUSHBUTTON_STEP = 2'b01,
        MODE_EXT_STEP = 2'b10
    } tpsq_mode_t;

    typedef enum logic [1:0] {
        PAT_SELECTED = 2'b00,
        PAT_PANGRAM = 2'b01,
        PAT_RANDOM = 2'b10,
        PAT_REVERSAL = 2'b11
    } tpsq_pattern_t;

    // pangram_test_message in both codes, first character first
    localparam logic [7:0] MSG_ASCII [MSG_LEN] = '{
        8'h51, 8'h55, 8'h49, 8'h43, 8'h4b, 8'h20, 8'h42, 8'h52,
        8'h4f, 8'h57, 8'h4e, 8'h20, 8'h46, 8'h4f, 8'h58, 8'h20};
    localparam logic [4:0] MSG_BAUDOT [MSG_LEN] = '{
        5'h17, 5'h07, 5'h06, 5'h0e, 5'h0f, 5'h04, 5'h19, 5'h0a,
        5'h18, 5'h13, 5'h0c, 5'h04, 5'h16, 5'h18, 5'h1d, 5'h04};
endpackage

/* File: design/tpsq_tb_if.sv */
`timescale 1ns/1ps
interface tpsq_tb_if;
    logic [3:0] rate_pos;
    logic range_b;
    logic ext_timing;
    logic run;
    logic tick;
    modport tb (input rate_pos, input range_b, input ext_timing, input run, output tick);
    modport core (output rate_pos, output range_b, output ext_timing, output run, input tick);
endinterface

/* File: design/tpsq_time_base.sv */
`timescale 1ns/1ps
module tpsq_time_base #(
    parameter int DIV_W = 8
) (
    input wire logic sys_clk_i, // system clock
    input wire logic resetn_i, // sync reset, active low
    tpsq_tb_if.tb tb // rate select, run and 100x tick
);
    import tpsq_pkg::*;

    logic [DIV_W-1:0] div_reg;
    logic toggle_reg;
    logic tick_reg;
    logic ext_prev_reg;
    logic sel_stb;

    // terminal test for a power-of-two tap
    function automatic logic tap_hit(input logic [DIV_W-1:0] cnt, input int k);
        logic [DIV_W-1:0] mask;
        mask = DIV_W'((1 << k) - 1);
        return (cnt & mask) == mask;
    endfunction

    // at most one gate of the selection network passes; none at unused rate positions
    always_comb begin
        sel_stb = 1'b0;
        if (tb.range_b) begin
            unique case (tb.rate_pos)
                4'h0, 4'h1: sel_stb = tap_hit(div_reg, 5);
                4'h2, 4'h3: sel_stb = tap_hit(div_reg, 4);
                4'h4, 4'h5: sel_stb = 1'b1;
                default: sel_stb = 1'b0;
            endcase
        end else if (tb.rate_pos == RATE_POS_EXT) begin
            sel_stb = ext_prev_reg & ~tb.ext_timing;
        end else if (tb.rate_pos == RATE_POS_192) begin
            sel_stb = div_reg == DIV_192_LAST;
        end else if (tb.rate_pos < RATE_POS_192) begin
            sel_stb = tap_hit(div_reg, int'(tb.rate_pos));
        end
    end

    // 192 comes from cutting the binary count short
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i || !tb.run) begin
            div_reg <= '0;
        end else if (!tb.range_b && tb.rate_pos == RATE_POS_192 && div_reg == DIV_192_LAST) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i || !tb.run) begin
            toggle_reg <= 1'b1;
        end else if (sel_stb) begin
            toggle_reg <= ~toggle_reg;
        end
    end

    // tick on the high-to-low move of the output stage
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= tb.run & sel_stb & toggle_reg;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            ext_prev_reg <= 1'b0;
        end else begin
            ext_prev_reg <= tb.ext_timing;
        end
    end

    assign tb.tick = tick_reg;

    run_low_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        !tb.run |=> toggle_reg && div_reg == '0 && !tick_reg)
        else $error("time base not held while stopped");

    tick_pair_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        tick_reg |-> !toggle_reg && $past(toggle_reg))
        else $error("tick without output stage falling");
endmodule

/* File: design/tpsq_pattern_sequencer.sv */
// The Avalon-MM interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
module tpsq_pattern_sequencer (
    input wire logic sys_clk_i, // system clock, 100 MHz
    input wire logic resetn_i, // sync reset, active low
    input wire logic [5:0] avs_address_i, // byte address
    input wire logic avs_read_i, // read request
    input wire logic avs_write_i, // write request
    input wire logic [31:0] avs_writedata_i, // write data
    input wire logic [3:0] avs_byteenable_i, // byte lanes
    output logic [31:0] avs_readdata_o, // read data
    output logic avs_waitrequest_o, // stall
    input wire logic step_in_i, // external step, falling edge
    input wire logic ext_timing_i, // external bit timing
    output logic line_data_o, // serial line, 1 = mark
    output logic load_req_o, // load request pulse
    output logic char_end_o, // halted at character end
    output logic shift_strobe_o, // bit shift pulse
    output logic time_base_run_o // time base enabled
);
    import tpsq_pkg::*;

    tpsq_tb_if tb_if ();

    logic [31:0] ctrl_reg;
    logic [7:0] char_reg [SEL_CHARS];
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic step_wr_reg;
    logic ext_prev_reg;
    logic [6:0] bit_cnt_reg;
    logic stb_reg;
    logic load_req_reg;
    logic load_pend_reg;
    logic char_end_reg;
    logic msg_en_reg;
    logic msg_done_reg;
    logic [3:0] sel_cnt_reg;
    logic [3:0] msg_cnt_reg;
    logic [REG_STAGES-1:0] shreg_reg;
    logic final_reg;
    logic [3:0] bits_left_reg;
    logic [8:0] lfsr_reg;
    logic rev_reg;

    tpsq_mode_t mode;
    tpsq_pattern_t pattern;
    logic code8;
    logic [2:0] seq_len;
    logic access;
    logic wr_go;
    logic serial_mode;
    logic empty;
    logic step_pulse;
    logic tb_run;
    logic ser_in;
    logic [9:0] dec;
    logic [7:0] sel_char;
    logic [7:0] msg_char;
    logic [7:0] matrix_data;
    logic fill_mark;
    logic [FRAME_BITS-1:0] frame;
    logic [3:0] frame_len;
    logic [31:0] status;

    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [9:0] bcd_to_dec(input logic [3:0] bcd);
        logic [9:0] res;
        res = '0;
        if (bcd < 4'ha) begin
            res[bcd] = 1'b1;
        end
        return res;
    endfunction

    // start space, data lsb first, stop marks
    function automatic logic [FRAME_BITS-1:0] build_frame(input logic [7:0] d, input logic c8);
        logic [FRAME_BITS-1:0] res;
        if (c8) begin
            res = {2'b11, d, 1'b0};
        end else begin
            res = {5'h1f, d[4:0], 1'b0};
        end
        return res;
    endfunction

    assign mode = tpsq_mode_t'(ctrl_reg[CTRL_MODE_LSB +: 2]);
    assign pattern = tpsq_pattern_t'(ctrl_reg[CTRL_PAT_LSB +: 2]);
    assign code8 = ctrl_reg[CTRL_CODE8];
    assign seq_len = ctrl_reg[CTRL_LEN_LSB +: 3];

    // avalon slave: one wait state on every access
    assign access = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = access & ~ack_reg;
    assign wr_go = avs_write_i & ack_reg;
    assign avs_readdata_o = rdata_reg;

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= access & ~ack_reg;
        end
    end

    assign status = {16'h0000, msg_cnt_reg, sel_cnt_reg, bits_left_reg, 1'b0, tb_run,
                     char_end_reg, msg_en_reg};

    // unmapped offsets read as zero and ignore writes
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            rdata_reg <= '0;
        end else if (avs_read_i && !ack_reg) begin
            rdata_reg <= '0;
            if (avs_address_i == OFS_CTRL) begin
                rdata_reg <= ctrl_reg;
            end else if (avs_address_i == OFS_STATUS) begin
                rdata_reg <= status;
            end
            for (int i = 0; i < SEL_CHARS; i++) begin
                if (avs_address_i == OFS_CHAR0 + 6'(4 * i)) begin
                    rdata_reg <= {24'h000000, char_reg[i]};
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr_go && avs_address_i == OFS_CTRL) begin
            ctrl_reg <= be_merge(ctrl_reg, avs_writedata_i, avs_byteenable_i);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < SEL_CHARS; i++) begin
                char_reg[i] <= CHAR_RESET;
            end
        end else begin
            for (int i = 0; i < SEL_CHARS; i++) begin
                if (wr_go && avs_address_i == OFS_CHAR0 + 6'(4 * i) && avs_byteenable_i[0]) begin
                    char_reg[i] <= avs_writedata_i[7:0];
                end
            end
        end
    end

    // the pushbutton is a write of bit 0 to the step register
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            step_wr_reg <= 1'b0;
        end else begin
            step_wr_reg <= wr_go && avs_address_i == OFS_STEP && avs_byteenable_i[0]
                           && avs_writedata_i[0];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            ext_prev_reg <= 1'b0;
        end else begin
            ext_prev_reg <= step_in_i;
        end
    end

    always_comb begin
        step_pulse = 1'b0;
        unique case (mode)
            MODE_PUSHBUTTON_STEP: step_pulse = step_wr_reg;
            MODE_EXT_STEP: step_pulse = ext_prev_reg & ~step_in_i;
            default: step_pulse = 1'b0;
        endcase
    end

    // time base stops while halted at a character end
    assign tb_run = ctrl_reg[CTRL_RUN] & ~char_end_reg;
    assign tb_if.rate_pos = ctrl_reg[CTRL_RATE_LSB +: 4];
    assign tb_if.range_b = ctrl_reg[CTRL_RANGE_B];
    assign tb_if.ext_timing = ext_timing_i;
    assign tb_if.run = tb_run;

    tpsq_time_base #(.DIV_W(8)) u_time_base (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .tb(tb_if)
    );

    // one hundred ticks per bit
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i || !tb_run) begin
            bit_cnt_reg <= '0;
        end else if (tb_if.tick) begin
            bit_cnt_reg <= (bit_cnt_reg == TICKS_LAST) ? 7'h00 : bit_cnt_reg + 7'h01;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            stb_reg <= 1'b0;
        end else begin
            stb_reg <= tb_run & tb_if.tick & (bit_cnt_reg == TICKS_LAST);
        end
    end

    assign serial_mode = pattern == PAT_RANDOM || pattern == PAT_REVERSAL;
    assign empty = bits_left_reg <= 4'h1;

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            load_req_reg <= 1'b0;
        end else begin
            load_req_reg <= !serial_mode && ((stb_reg && empty && mode == MODE_FREE_RUN)
                            || (step_pulse && char_end_reg));
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            load_pend_reg <= 1'b0;
        end else begin
            load_pend_reg <= load_req_reg;
        end
    end

    // a new halt wins over a step in the same cycle
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i || mode == MODE_FREE_RUN) begin
            char_end_reg <= 1'b0;
        end else if (stb_reg && empty && !serial_mode) begin
            char_end_reg <= 1'b1;
        end else if (step_pulse) begin
            char_end_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            msg_en_reg <= 1'b0;
        end else if (load_req_reg) begin
            msg_en_reg <= 1'b1;
        end else if (msg_done_reg) begin
            msg_en_reg <= 1'b0;
        end
    end

    // counters start on their last value so the first load takes position 0
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            sel_cnt_reg <= SEL_LAST;
        end else if (load_req_reg && pattern == PAT_SELECTED) begin
            sel_cnt_reg <= (sel_cnt_reg == SEL_LAST) ? 4'h0 : sel_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            msg_cnt_reg <= MSG_LAST;
        end else if (load_req_reg && pattern == PAT_PANGRAM) begin
            msg_cnt_reg <= (msg_cnt_reg == MSG_LAST) ? 4'h0 : msg_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            msg_done_reg <= 1'b0;
        end else begin
            msg_done_reg <= load_pend_reg && pattern == PAT_PANGRAM && msg_cnt_reg == MSG_LAST;
        end
    end

    // character matrix
    assign dec = bcd_to_dec(sel_cnt_reg);
    always_comb begin
        sel_char = '0;
        for (int i = 0; i < SEL_CHARS; i++) begin
            if (dec[i] && msg_en_reg) begin
                sel_char = sel_char | char_reg[i];
            end
        end
    end

    assign msg_char = code8 ? MSG_ASCII[msg_cnt_reg] : {3'b000, MSG_BAUDOT[msg_cnt_reg]};

    always_comb begin
        matrix_data = '0;
        unique case (pattern)
            PAT_SELECTED: matrix_data = sel_char;
            PAT_PANGRAM: matrix_data = msg_en_reg ? msg_char : 8'h00;
            default: matrix_data = '0;
        endcase
    end

    assign fill_mark = !msg_en_reg
                       || (pattern == PAT_SELECTED && sel_cnt_reg >= {1'b0, seq_len});
    assign frame = fill_mark ? MARK_FILL : build_frame(matrix_data, code8);
    assign frame_len = code8 ? FRAME_LEN_8 : FRAME_LEN_5;

    // serial patterns
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            lfsr_reg <= LFSR_SEED;
            rev_reg <= 1'b0;
        end else if (stb_reg) begin
            lfsr_reg <= {lfsr_reg[4] ^ lfsr_reg[0], lfsr_reg[8:1]};
            rev_reg <= ~rev_reg;
        end
    end

    assign ser_in = !serial_mode ? 1'b1 : (pattern == PAT_RANDOM ? lfsr_reg[0] : rev_reg);

    // final stage drives the line, ten stages feed it
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            shreg_reg <= '1;
            final_reg <= 1'b1;
            bits_left_reg <= '0;
        end else if (load_pend_reg && !serial_mode) begin
            {shreg_reg, final_reg} <= frame;
            bits_left_reg <= frame_len;
        end else if (stb_reg && (serial_mode || !empty)) begin
            final_reg <= shreg_reg[0];
            shreg_reg <= {ser_in, shreg_reg[REG_STAGES-1:1]};
            bits_left_reg <= (bits_left_reg == 4'h0) ? 4'h0 : bits_left_reg - 4'h1;
        end
    end

    assign line_data_o = final_reg;
    assign load_req_o = load_req_reg;
    assign char_end_o = char_end_reg;
    assign shift_strobe_o = stb_reg;
    assign time_base_run_o = tb_run;

    load_empty_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        stb_reg && empty && mode == MODE_FREE_RUN && !serial_mode |=> load_req_reg)
        else $error("no load request on empty register");

    serial_noload_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        serial_mode && $past(serial_mode) |-> !load_req_reg)
        else $error("load request in serial pattern");

    sel_step_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        load_req_reg && pattern == PAT_SELECTED && sel_cnt_reg != SEL_LAST
        |=> sel_cnt_reg == $past(sel_cnt_reg) + 4'h1)
        else $error("programmed sequencer did not advance");

    msg_step_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        load_req_reg && pattern == PAT_PANGRAM && msg_cnt_reg == (MSG_LAST - 4'h1)
        |=> msg_cnt_reg == MSG_LAST ##1 msg_done_reg ##1 !msg_en_reg)
        else $error("message wrap or completion reset wrong");

    msg_en_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        load_req_reg |=> msg_en_reg && load_pend_reg)
        else $error("message enable not raised by load");

    halt_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        char_end_reg && !step_pulse |=> char_end_reg && !stb_reg && !load_req_reg)
        else $error("output continued while halted");

    mark_fill_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        load_pend_reg && pattern == PAT_SELECTED && sel_cnt_reg >= {1'b0, seq_len}
        |=> {shreg_reg, final_reg} == MARK_FILL)
        else $error("interval past length not mark");

    frame_len_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        load_pend_reg && !serial_mode |=> bits_left_reg == (code8 ? FRAME_LEN_8 : FRAME_LEN_5)
        && final_reg == $past(frame[0]))
        else $error("frame not loaded whole");
endmodule

/* File: verification/tpsq_line_partner.sv */
`timescale 1ns/1ps
module tpsq_line_partner #(
    parameter int BIT_CYC = 200,
    parameter int STEP_DLY = 5
) (
    input wire logic clk_i, // system clock
    input wire logic line_i, // serial line, 1 = mark
    input wire logic char_end_i, // device halted
    input wire logic step_en_i, // answer halts with a step
    output logic step_o, // step line, idle high
    output logic rx_valid_o, // one frame received
    output logic [5:0] rx_char_o // {stop, data}
);
    int cnt = 0;
    int bitn = 0;
    int dly = 0;
    logic [5:0] sh = '0;
    initial step_o = 1'b1;
    initial rx_valid_o = 1'b0;
    initial rx_char_o = '0;
    // mid-bit sampling, so a wrong bit time shows up as wrong data
    always @(posedge clk_i) begin
        rx_valid_o <= 1'b0;
        cnt <= cnt + 1;
        if (bitn == 0 && line_i) begin
            cnt <= 0;
        end else if (bitn == 0 && cnt == BIT_CYC / 2) begin
            bitn <= 1;
            cnt <= 0;
        end else if (bitn != 0 && cnt == BIT_CYC - 1) begin
            cnt <= 0;
            sh <= {line_i, sh[5:1]};
            bitn <= (bitn == 6) ? 0 : bitn + 1;
            rx_valid_o <= (bitn == 6);
            rx_char_o <= {line_i, sh[5:1]};
        end
    end
    // external step source: falling edge some cycles after a halt
    always @(posedge clk_i) begin
        dly <= (step_en_i && char_end_i) ? dly + 1 : 0;
        step_o <= !(dly >= STEP_DLY && dly < STEP_DLY + 4);
    end
endmodule

/* File: verification/tpsq_pattern_sequencer_tb_top.sv */
`timescale 1ns/1ps
module tpsq_pattern_sequencer_tb_top;
    import tpsq_pkg::*;
    logic clk = 0, rstn = 0, rd = 0, wr = 0, step_en = 0, step, rxv;
    logic [5:0] adr = '0, rxc, got;
    logic [31:0] wd = '0, rdat, q;
    logic wait_r, line, ld, cend, sstr, tbrun;
    logic [4:0] ch [SEL_CHARS];
    logic [5:0] rxq [$];
    int error_cnt = 0, n_tests = 0, ld_cnt = 0, tog = 0, seed = 32'hb90ca91a;
    int ld0 = 0, tog0 = 0, sgap = 0, sper = 0;
    logic line_d = 1'b1;
    logic ext_t = 1'b0;
    always #5 clk = ~clk;
    tpsq_pattern_sequencer i_tpsq_pattern_sequencer (.sys_clk_i(clk), .resetn_i(rstn),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
        .avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_r),
        .step_in_i(step), .ext_timing_i(ext_t), .line_data_o(line), .load_req_o(ld),
        .char_end_o(cend), .shift_strobe_o(sstr), .time_base_run_o(tbrun));
    tpsq_line_partner i_tpsq_line_partner (.clk_i(clk), .line_i(line), .char_end_i(cend),
        .step_en_i(step_en), .step_o(step), .rx_valid_o(rxv), .rx_char_o(rxc));
    always @(posedge clk) begin
        if (rxv) rxq.push_back(rxc);
        ld_cnt <= ld_cnt + int'(ld === 1'b1);
        line_d <= line;
        tog <= tog + int'(line !== line_d);
        // external timing falls every second cycle
        ext_t <= ~ext_t;
        sgap <= (sstr === 1'b1) ? 0 : sgap + 1;
        if (sstr === 1'b1) sper <= sgap + 1;
    end
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        // only the watchdog ends a wait that never comes
        do begin
            @(posedge clk);
        end while (wait_r !== 1'b0);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    task automatic do_reset();
        rstn <= 1'b0;
        step_en <= 1'b0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        rxq.delete();
    endtask
    // waits at most a few frames; an empty queue yields unknowns
    task automatic get_char();
        int n = 0;
        while (rxq.size() == 0 && n < 12000) begin
            @(posedge clk);
            n++;
        end
        got = rxq.size() ? rxq.pop_front() : 6'bx;
    endtask
    // range B position 4 divides by one: 200 cycles a bit
    function automatic logic [31:0] ctrl(input logic [1:0] m, p, input logic [2:0] len);
        ctrl = '0;
        ctrl[CTRL_RUN] = 1'b1;
        ctrl[CTRL_MODE_LSB +: 2] = m;
        ctrl[CTRL_PAT_LSB +: 2] = p;
        ctrl[CTRL_RATE_LSB +: 4] = 4'h4;
        ctrl[CTRL_RANGE_B] = 1'b1;
        ctrl[CTRL_LEN_LSB +: 3] = len;
    endfunction
    task automatic load_chars();
        for (int i = 0; i < SEL_CHARS; i++) begin
            ch[i] = 5'($random(seed));
            bus(1, OFS_CHAR0 + 6'(4 * i), {27'h0, ch[i]});
        end
    endtask
    task automatic finish_test();
        $display("tests %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge clk);
        error_cnt++;
        finish_test();
    end
    initial begin
        do_reset();
        bus(0, OFS_CTRL, 0);
        chk("ctrl reset", CTRL_RESET, q);
        bus(0, OFS_STATUS, 0);
        chk("status reset", 32'hf500, q & 32'hff07);
        bus(1, 6'h24, 32'h1234);
        bus(0, 6'h24, 0);
        chk("unmapped", 0, q);
        $display("register test done");
        load_chars();
        bus(1, OFS_CTRL, ctrl(0, 0, 3));
        for (int k = 0; k < 4; k++) begin
            get_char();
            chk("selected char", {1'b1, ch[k % 3]}, got);
        end
        $display("selected test done");
        do_reset();
        bus(1, OFS_CTRL, ctrl(0, 1, 6));
        for (int k = 0; k <= MSG_LEN; k++) begin
            get_char();
            chk("pangram char", {1'b1, MSG_BAUDOT[k % MSG_LEN]}, got);
        end
        $display("pangram test done");
        for (int m = 1; m <= 2; m++) begin
            do_reset();
            load_chars();
            bus(1, OFS_CTRL, ctrl(2'(m), 0, 1));
            repeat (2000) @(posedge clk);
            chk("halt", 2'b10, {cend, tbrun});
            chk("no output while halted", 0, rxq.size());
            if (m == 1) bus(1, OFS_STEP, 1);
            else step_en <= 1'b1;
            get_char();
            chk("stepped char", {1'b1, ch[0]}, got);
            $display("step mode %0d test done", m);
        end
        for (int p = 2; p <= 3; p++) begin
            do_reset();
            bus(1, OFS_CTRL, ctrl(0, 2'(p), 6));
            ld0 = ld_cnt;
            tog0 = tog;
            // random line holds nine seed marks first, so wait past strobe 30
            repeat (7000) @(posedge clk);
            chk("serial pattern loads", 0, ld_cnt - ld0);
            chk("serial pattern moves", 1, (tog - tog0) > 2);
            chk("shift strobe period", 200, sper);
        end
        $display("serial pattern test done");
        do_reset();
        bus(1, OFS_CTRL, (ctrl(0, 3, 6) & ~32'h7c0) | (32'(RATE_POS_EXT) << CTRL_RATE_LSB));
        repeat (3000) @(posedge clk);
        chk("ext timing strobe period", 400, sper);
        bus(1, OFS_CTRL, ctrl(0, 0, 6) | (32'h1 << CTRL_CODE8));
        @(posedge clk iff ld === 1'b1);
        bus(0, OFS_STATUS, 0);
        chk("8-level bits left", FRAME_LEN_8, q[STAT_BITS_LSB +: 4]);
        $display("timing and code test done");
        finish_test();
    end
endmodule
